/* core/beam_diag_pkg.sv */
// constants and types for the beam diagnostic mode controller
package beam_diag_pkg;
   localparam int unsigned CLK_HZ = 100_000_000; // core clock rate
   localparam int unsigned TICK_CYC = CLK_HZ / 1000; // cycles per millisecond tick
   localparam int unsigned DEBOUNCE_MS = 20; // button must be stable this long
   localparam int unsigned LONG_MS = 13_000; // diag toggle hold time
   localparam int unsigned MODE_MS = 2_000; // mode change hold, and short press limit
   localparam int unsigned BLINK_MS = 250; // half period of flashing
   localparam logic [13:0] MS_MAX = 14'h3FFF; // saturation of the press timer

   typedef enum logic [1:0] {
      NORMAL_RUN,
      MANUAL_ALIGN,
      ADJUST_ALIGN
   } op_mode_e;

   // three mode indicators driven as a group
   typedef struct packed {
      logic normal_run_mode;
      logic manual_align_mode;
      logic adjust_align_mode;
   } mode_ind_s;
endpackage : beam_diag_pkg

/* core/beam_diag_mode_controller.sv */
// mode controller with diagnostic latch of beam interruptions
`timescale 1ns/1ps
`default_nettype none
module beam_diag_mode_controller #(
   parameter int unsigned TICK_CYC = beam_diag_pkg::TICK_CYC // shorten in simulation
) (
   input wire logic core_clk_i, // 100 MHz clock
   input wire logic rst_i, // synchronous reset, active high
   input wire logic button_i, // mode button, high while pressed
   input wire logic beam_ok_i, // receive level above switch-off threshold
   input wire logic peer_manual_i, // peer reports it is in manual mode
   input wire logic peer_press_i, // peer button press pulse
   output var beam_diag_pkg::mode_ind_s ind_o, // mode indicators, high is lit
   output logic diag_o, // diagnostic mode active
   output logic press_to_peer_o, // short press in manual/adjust, for peer
   output logic link_ok_o // data path enable, same as normal mode except held off in adjust
);
   localparam int unsigned DB_MS = beam_diag_pkg::DEBOUNCE_MS;
   localparam int unsigned LG_MS = beam_diag_pkg::LONG_MS;
   localparam int unsigned MD_MS = beam_diag_pkg::MODE_MS;
   localparam int unsigned BK_MS = beam_diag_pkg::BLINK_MS;

   logic [16:0] tick_cnt_r; // divider to millisecond tick
   logic tick; // one cycle every millisecond
   logic [4:0] db_cnt_r; // debounce ms counter
   logic btn_r; // debounced button level
   logic btn_d_r; // previous debounced level
   logic [13:0] hold_r; // ms the button has been held
   logic [7:0] blink_cnt_r; // blink half-period counter
   logic blink_r; // flashing phase
   beam_diag_pkg::op_mode_e mode_r; // current operating mode
   beam_diag_pkg::op_mode_e mode_nxt;
   logic diag_r; // diagnostic mode active
   logic diag_nxt;
   logic latch_r; // beam interruption latched
   logic release_ev; // debounced release seen
   logic short_rel; // release of a short press
   logic long_rel; // release after more than 13 s
   logic mid_rel; // release after 2 s up to 13 s
   logic press_ev; // debounced press seen

   // free running millisecond tick
   assign tick = (tick_cnt_r == 17'(TICK_CYC - 1));
   always_ff @(posedge core_clk_i) begin
      if (rst_i || tick) tick_cnt_r <= 17'h00000;
      else tick_cnt_r <= tick_cnt_r + 17'h00001;
   end

   // debounce: accept a new level only after it stays for DB_MS ticks
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         db_cnt_r <= 5'h00;
         btn_r <= 1'b0;
      end else if (button_i == btn_r) begin
         db_cnt_r <= 5'h00;
      end else if (tick) begin
         if (db_cnt_r == 5'(DB_MS - 1)) begin
            btn_r <= button_i;
            db_cnt_r <= 5'h00;
         end else begin
            db_cnt_r <= db_cnt_r + 5'h01;
         end
      end
   end

   // press duration in ms, held after release so the release edge can classify it
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         btn_d_r <= 1'b0;
         hold_r <= 14'h0000;
      end else begin
         btn_d_r <= btn_r;
         if (press_ev) hold_r <= 14'h0000;
         else if (btn_r && tick && hold_r != beam_diag_pkg::MS_MAX) hold_r <= hold_r + 14'h0001;
      end
   end

   assign press_ev = btn_r && !btn_d_r;
   assign release_ev = !btn_r && btn_d_r;
   assign short_rel = release_ev && (hold_r < 14'(MD_MS));
   assign long_rel = release_ev && (hold_r > 14'(LG_MS));
   assign mid_rel = release_ev && (hold_r > 14'(MD_MS)) && (hold_r <= 14'(LG_MS));

   // mode and diagnostic decisions act on a release or on a peer press pulse; holding the button alone never changes them
   always_comb begin
      mode_nxt = mode_r;
      diag_nxt = diag_r;
      if (diag_r) begin
         if (long_rel) diag_nxt = 1'b0;
      end else begin
         unique case (mode_r)
            beam_diag_pkg::NORMAL_RUN: begin
               if (long_rel) diag_nxt = 1'b1;
               else if (mid_rel) mode_nxt = beam_diag_pkg::MANUAL_ALIGN;
            end
            beam_diag_pkg::MANUAL_ALIGN: begin
               // both ends must be manual before adjust is taken
               if ((short_rel || peer_press_i) && peer_manual_i)
                  mode_nxt = beam_diag_pkg::ADJUST_ALIGN;
               else if (mid_rel || long_rel) mode_nxt = beam_diag_pkg::NORMAL_RUN;
            end
            beam_diag_pkg::ADJUST_ALIGN: begin
               if (short_rel || peer_press_i) mode_nxt = beam_diag_pkg::MANUAL_ALIGN;
            end
            // the fourth code is never entered; recover to normal run if upset
            default: mode_nxt = beam_diag_pkg::NORMAL_RUN;
         endcase
      end
   end

   // mode registers; diag only flips locally, nothing is sent to the peer
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         mode_r <= beam_diag_pkg::NORMAL_RUN;
         diag_r <= 1'b0;
      end else begin
         mode_r <= mode_nxt;
         diag_r <= diag_nxt;
      end
   end

   // interruption latch: loss sets it, a short press clears it; loss wins a tie
   always_ff @(posedge core_clk_i) begin
      if (rst_i || !diag_r) latch_r <= 1'b0;
      else if (!beam_ok_i) latch_r <= 1'b1;
      else if (short_rel) latch_r <= 1'b0;
   end

   // blink phase generator from the millisecond tick
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         blink_cnt_r <= 8'h00;
         blink_r <= 1'b0;
      end else if (tick) begin
         if (blink_cnt_r == 8'(BK_MS - 1)) begin
            blink_cnt_r <= 8'h00;
            blink_r <= !blink_r;
         end else begin
            blink_cnt_r <= blink_cnt_r + 8'h01;
         end
      end
   end

   // indicator drive, registered
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         ind_o <= '0;
      end else if (diag_r) begin
         ind_o <= latch_r ? {3{blink_r}} : 3'h7;
      end else begin
         ind_o.normal_run_mode <= (mode_r == beam_diag_pkg::NORMAL_RUN);
         ind_o.manual_align_mode <= (mode_r == beam_diag_pkg::MANUAL_ALIGN);
         // adjust lamp flashes while the beam is missing
         ind_o.adjust_align_mode <= (mode_r == beam_diag_pkg::ADJUST_ALIGN)
            && (beam_ok_i || blink_r);
      end
   end

   // data path follows normal thresholds in diag; adjust separates the data path
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         diag_o <= 1'b0;
         link_ok_o <= 1'b0;
         press_to_peer_o <= 1'b0;
      end else begin
         diag_o <= diag_r;
         link_ok_o <= beam_ok_i && (diag_r || mode_r != beam_diag_pkg::ADJUST_ALIGN);
         press_to_peer_o <= short_rel && !diag_r && (mode_r != beam_diag_pkg::NORMAL_RUN);
      end
   end

   property p_diag_entry;
      @(posedge core_clk_i) disable iff (rst_i)
      (!diag_r && mode_r == beam_diag_pkg::NORMAL_RUN && long_rel) |=> diag_r;
   endproperty
   a_diag_entry: assert property (p_diag_entry) else $error("diag not entered");

   property p_steady;
      @(posedge core_clk_i) disable iff (rst_i)
      (diag_r && !latch_r) |=> ind_o == 3'h7;
   endproperty
   a_steady: assert property (p_steady) else $error("indicators not steady");

   property p_loss_latch;
      @(posedge core_clk_i) disable iff (rst_i)
      (diag_r && !beam_ok_i && !long_rel) |=> latch_r;
   endproperty
   a_loss_latch: assert property (p_loss_latch) else $error("loss not latched");

   property p_hold_latch;
      @(posedge core_clk_i) disable iff (rst_i)
      (latch_r && diag_r && !short_rel && !long_rel) |=> latch_r;
   endproperty
   a_hold_latch: assert property (p_hold_latch) else $error("latch dropped");

   property p_ack;
      @(posedge core_clk_i) disable iff (rst_i)
      (latch_r && short_rel && beam_ok_i) |=> (!latch_r && diag_r) ##1 ind_o == 3'h7;
   endproperty
   a_ack: assert property (p_ack) else $error("acknowledge failed");

   property p_exit;
      @(posedge core_clk_i) disable iff (rst_i)
      (diag_r && !long_rel) |=> diag_r;
   endproperty
   a_exit: assert property (p_exit) else $error("diag left without long press");

   property p_link;
      @(posedge core_clk_i) disable iff (rst_i)
      diag_r |=> link_ok_o == $past(beam_ok_i);
   endproperty
   a_link: assert property (p_link) else $error("data path altered");

   property p_short;
      @(posedge core_clk_i) disable iff (rst_i)
      short_rel |-> !long_rel && !mid_rel;
   endproperty
   a_short: assert property (p_short) else $error("press class overlap");

   // debounced level may only move at the end of a full debounce count,
   // so a bouncing contact can never classify a press on its own
   property p_debounce;
      @(posedge core_clk_i) disable iff (rst_i)
      (!$past(rst_i) && $changed(btn_r)) |-> $past(tick) && ($past(db_cnt_r) == 5'(DB_MS - 1));
   endproperty
   a_debounce: assert property (p_debounce) else $error("button level taken early");
endmodule : beam_diag_mode_controller
`default_nettype wire

/* sim/beam_far_side.sv */
// operator button and opposing transceiver model
`timescale 1ns/1ps
`default_nettype none
module beam_far_side (
   input wire logic clk_i, // bench clock
   output logic button_o, // mode button, high pressed
   output logic beam_ok_o, // receive level above cutoff
   output logic peer_manual_o, // peer sits in manual mode
   output logic peer_press_o // peer short press pulse
);
   // idle: beam present, button up, peer in normal mode
   initial begin
      button_o = 1'h0;
      beam_ok_o = 1'h1;
      peer_manual_o = 1'h0;
      peer_press_o = 1'h0;
   end
   // hold the button for a number of clock cycles, moves only on falling edges
   task automatic press(input int unsigned ms);
      @(negedge clk_i) button_o = 1'h1;
      repeat (ms) @(negedge clk_i);
      button_o = 1'h0;
   endtask : press
   // interrupt the beam for some cycles, then restore it
   task automatic drop(input int unsigned cyc);
      @(negedge clk_i) beam_ok_o = 1'h0;
      repeat (cyc) @(negedge clk_i);
      beam_ok_o = 1'h1;
   endtask : drop
   // peer reports its mode and sends one press pulse
   task automatic peer_press(input logic manual);
      @(negedge clk_i) peer_manual_o = manual;
      peer_press_o = 1'h1;
      @(negedge clk_i) peer_press_o = 1'h0;
   endtask : peer_press
   // random receive level each cycle, beam restored afterwards
   task automatic noise(input int unsigned cyc);
      repeat (cyc) @(negedge clk_i) beam_ok_o = 1'($urandom_range(1));
      @(negedge clk_i) beam_ok_o = 1'h1;
   endtask : noise
endmodule : beam_far_side
`default_nettype wire

/* sim/beam_diag_mode_controller_tb.sv */
// self-checking bench for the beam diagnostic mode controller
`timescale 1ns/1ps
`default_nettype none
module beam_diag_mode_controller_tb;
   logic core_clk_i; // bench clock
   logic rst_i; // synchronous reset
   logic button_i, beam_ok_i, peer_manual_i, peer_press_i; // far side lines
   beam_diag_pkg::mode_ind_s ind_o; // indicators
   logic diag_o, press_to_peer_o, link_ok_o; // status outputs
   logic beam_q; // beam level seen at the last rising edge
   int mismatches = 0;
   int total_checks = 0;
   int peer_pulses = 0; // presses sent to the peer while in diag
   int out_pulses = 0; // presses sent to the peer outside diag
   // one tick per cycle keeps 13 s presses inside the run length
   beam_diag_mode_controller #(.TICK_CYC(1)) dut (.core_clk_i(core_clk_i), .rst_i(rst_i),
      .button_i(button_i), .beam_ok_i(beam_ok_i), .peer_manual_i(peer_manual_i),
      .peer_press_i(peer_press_i), .ind_o(ind_o), .diag_o(diag_o),
      .press_to_peer_o(press_to_peer_o), .link_ok_o(link_ok_o));
   beam_far_side far (.clk_i(core_clk_i), .button_o(button_i), .beam_ok_o(beam_ok_i),
      .peer_manual_o(peer_manual_i), .peer_press_o(peer_press_i));
   initial begin
      core_clk_i = 1'h0;
      forever #5 core_clk_i = ~core_clk_i;
   end
   task automatic check(input logic ok, input string msg);
      total_checks++;
      if (ok !== 1'h1) begin
         mismatches++;
         $display("[FAIL] %0t %s", $time, msg);
      end
   endtask : check
   task automatic finish_test();
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : finish_test
   // bounded wait for an indicator pattern
   task automatic wait_ind(input logic [2:0] exp, input int lim);
      int n;
      n = 0;
      while (ind_o !== exp && n < lim) begin
         @(negedge core_clk_i);
         n++;
      end
      check(ind_o === exp, "indicator pattern not reached");
   endtask : wait_ind
   // count indicator changes over a stretch; flashing toggles every 250 ticks
   task automatic toggles(input int cyc, output int t);
      logic [2:0] last;
      t = 0;
      last = ind_o;
      repeat (cyc) begin
         @(negedge core_clk_i);
         if (ind_o !== last) t++;
         last = ind_o;
      end
   endtask : toggles
   // data path in diag follows the beam one cycle late, as in normal mode
   always @(posedge core_clk_i) beam_q <= beam_ok_i;
   always @(negedge core_clk_i) begin
      if (diag_o === 1'h1) check(link_ok_o === beam_q, "data path altered in diag");
      if (diag_o === 1'h1 && press_to_peer_o !== 1'h0) peer_pulses++;
      if (diag_o === 1'h0 && press_to_peer_o === 1'h1) out_pulses++;
   end
   initial begin
      int t;
      int s;
      rst_i = 1'h1;
      s = $urandom(32'h7A98);
      repeat (10) @(negedge core_clk_i);
      check(ind_o === 3'h0 && diag_o === 1'h0, "outputs not cleared in reset");
      rst_i = 1'h0;
      wait_ind(3'h4, 5);
      far.press(13050);
      wait_ind(3'h7, 40);
      check(diag_o === 1'h1, "diag not entered");
      repeat (2) begin
         far.drop(1 + $urandom_range(4));
         toggles(600, t);
         check(t >= 2, "short interruption not flashed");
         far.noise(16);
         far.press(5000 + $urandom_range(3000));
         toggles(600, t);
         check(t >= 2 && diag_o === 1'h1, "latch lost on mid press");
         far.press(30 + $urandom_range(1900));
         repeat (40) @(negedge core_clk_i);
         toggles(600, t);
         check(t == 0 && ind_o === 3'h7 && diag_o === 1'h1, "ack not steady");
      end
      far.press(13050);
      wait_ind(3'h4, 40);
      check(diag_o === 1'h0 && peer_pulses == 0, "diag exit or peer leak");
      far.press(3000);
      wait_ind(3'h2, 40);
      far.peer_press(1'h0);
      repeat (4) @(negedge core_clk_i);
      check(ind_o === 3'h2, "adjust taken without peer in manual");
      far.peer_press(1'h1);
      wait_ind(3'h1, 40);
      fork
         far.drop(600);
         toggles(590, t);
      join
      check(t >= 2, "adjust indicator not flashing");
      far.press(100);
      wait_ind(3'h2, 40);
      check(out_pulses == 1, "short press not sent to peer");
      far.press(13050);
      wait_ind(3'h4, 40);
      check(diag_o === 1'h0, "diag entered from manual");
      finish_test();
   end
endmodule : beam_diag_mode_controller_tb
`default_nettype wire
